// *** src/mtwd_decoder.sv ***
// wake-up variant decoder of the load/unload command block
`default_nettype none

module mtwd_decoder #(
    parameter int POS_W = 32
) (
    // clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    // command block in
    input  wire logic              CMD_VALID,
    input  wire mtwd_pkg::mtwd_cdb_t CMD_CDB,
    output var  logic              CMD_READY,
    // status out
    output var  logic              STAT_VALID,
    output var  mtwd_pkg::mtwd_stat_t STAT,
    // ordinary load/unload handed on
    output var  logic              LU_FWD_VALID,
    output var  mtwd_pkg::mtwd_cdb_t LU_FWD_CDB,
    // tape mechanics
    input  wire logic [POS_W-1:0]  CUR_POS,
    input  wire logic              MECH_DONE,
    output var  logic              MECH_REQ,
    output var  logic [2:0]        MECH_OP,
    output var  logic [POS_W-1:0]  MECH_POS,
    output var  logic              MECH_DRAIN_BUF,
    output var  logic              MECH_WRITE_EOD,
    output var  logic              WAKE_MODE,
    // register port
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic [31:0]       REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output var  logic [31:0]       REG_RDATA
);
    localparam int NV_W = POS_W + 1;

    mtwd_pkg::mtwd_state_t state_q;
    logic                  immed_q;
    logic                  en_q;
    logic [POS_W-1:0]      saved_pos_q;
    logic                  nv_we_q;
    logic [NV_W-1:0]       nv_wdata_q;
    logic [NV_W-1:0]       nv_rdata;

    // decode of the offered block
    logic       take;
    logic       is_ours;
    logic       is_wake;
    logic [2:0] func;
    logic       immed;
    logic       rsv_func;
    logic       bad_mode;
    logic       bad_setup;
    logic       reject;
    logic       mech_fn;

    assign take     = CMD_VALID && CMD_READY;
    assign is_ours  = CMD_CDB.byte0 == mtwd_pkg::OPC_LOAD_UNLOAD;
    // spare vendor bit deliberately not decoded
    assign is_wake  = en_q && CMD_CDB.byte5[mtwd_pkg::SELECT_BIT];
    assign func     = CMD_CDB.byte4[mtwd_pkg::FUNC_LSB +: mtwd_pkg::FUNC_W];
    assign immed    = CMD_CDB.byte1[mtwd_pkg::IMMED_BIT];
    assign rsv_func = (func == mtwd_pkg::FN_RSV4) || (func == mtwd_pkg::FN_RSV6)
                   || (func == mtwd_pkg::FN_RSV7);
    assign bad_mode  = !rsv_func && !WAKE_MODE && (func != mtwd_pkg::FN_SETUP);
    assign bad_setup = !rsv_func && WAKE_MODE && (func == mtwd_pkg::FN_SETUP);
    assign reject    = rsv_func || bad_mode || bad_setup;
    assign mech_fn   = (func == mtwd_pkg::FN_SLEEP) || (func == mtwd_pkg::FN_WAKE)
                    || (func == mtwd_pkg::FN_UNLOAD);

    mtwd_nvstore #(
        .DW    (NV_W),
        .DEPTH (2),
        .AW    (1)
    ) u_nv (
        .clk     (SYS_CLK),
        .we      (nv_we_q),
        .waddr   (mtwd_pkg::NV_ADDR_STATE),
        .wdata   (nv_wdata_q),
        .raddr   (mtwd_pkg::NV_ADDR_STATE),
        .rdata_q (nv_rdata)
    );

    // sequencer: boot reload, idle decode, wait for mechanics
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_q   <= mtwd_pkg::S_BOOT;
            CMD_READY <= 1'b0;
            immed_q   <= 1'b0;
        end else begin
            unique case (state_q)
                mtwd_pkg::S_BOOT: begin
                    state_q   <= mtwd_pkg::S_IDLE;
                    CMD_READY <= 1'b1;
                end
                mtwd_pkg::S_IDLE: begin
                    if (take && is_ours && is_wake && !reject && mech_fn) begin
                        state_q   <= mtwd_pkg::S_EXEC;
                        CMD_READY <= 1'b0;
                        immed_q   <= immed;
                    end
                end
                mtwd_pkg::S_EXEC: begin
                    if (MECH_DONE) begin
                        state_q   <= mtwd_pkg::S_IDLE;
                        CMD_READY <= 1'b1;
                    end
                end
                default: begin
                    state_q   <= mtwd_pkg::S_BOOT;
                    CMD_READY <= 1'b0;
                end
            endcase
        end
    end

    // status return
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            STAT_VALID <= 1'b0;
            STAT       <= '0;
        end else begin
            STAT_VALID <= 1'b0;
            if (state_q == mtwd_pkg::S_IDLE && take && is_ours && is_wake) begin
                STAT_VALID     <= reject || !mech_fn || immed;
                STAT.status    <= reject ? mtwd_pkg::ST_CHECK : mtwd_pkg::ST_GOOD;
                STAT.sense_key <= reject ? mtwd_pkg::SK_ILLEGAL : mtwd_pkg::SK_NONE;
                STAT.ascq      <= mtwd_pkg::ASCQ_ZERO;
                if (rsv_func) begin
                    STAT.asc <= mtwd_pkg::ASC_BADFIELD;
                    STAT.fsc <= mtwd_pkg::FSC_RESERVED;
                end else if (bad_mode) begin
                    STAT.asc <= mtwd_pkg::ASC_SEQ;
                    STAT.fsc <= mtwd_pkg::FSC_NOTMODE;
                end else if (bad_setup) begin
                    STAT.asc <= mtwd_pkg::ASC_SEQ;
                    STAT.fsc <= mtwd_pkg::FSC_INMODE;
                end else begin
                    STAT.asc <= mtwd_pkg::ASC_NONE;
                    STAT.fsc <= mtwd_pkg::FSC_NONE;
                end
            end else if (state_q == mtwd_pkg::S_EXEC && MECH_DONE && !immed_q) begin
                STAT_VALID <= 1'b1;
                STAT       <= '0;
            end
        end
    end

    // ordinary command hand-on
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            LU_FWD_VALID <= 1'b0;
            LU_FWD_CDB   <= '0;
        end else begin
            LU_FWD_VALID <= state_q == mtwd_pkg::S_IDLE && take && is_ours && !is_wake;
            if (take) begin
                LU_FWD_CDB <= CMD_CDB;
            end
        end
    end

    // mechanics requests
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            MECH_REQ       <= 1'b0;
            MECH_OP        <= mtwd_pkg::FN_SLEEP;
            MECH_POS       <= '0;
            MECH_DRAIN_BUF <= 1'b0;
            MECH_WRITE_EOD <= 1'b0;
        end else begin
            MECH_REQ <= 1'b0;
            if (state_q == mtwd_pkg::S_IDLE && take && is_ours && is_wake && !reject
                    && mech_fn) begin
                MECH_REQ <= 1'b1;
                MECH_OP  <= func;
                MECH_POS <= saved_pos_q;
                // never flush or mark the end: the point is to save power and time
                MECH_DRAIN_BUF <= 1'b0;
                MECH_WRITE_EOD <= 1'b0;
            end
        end
    end

    // wake mode, saved position and their nonvolatile copy
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            WAKE_MODE   <= 1'b0;
            saved_pos_q <= '0;
            nv_we_q     <= 1'b0;
            nv_wdata_q  <= '0;
        end else begin
            nv_we_q <= 1'b0;
            if (state_q == mtwd_pkg::S_BOOT) begin
                // store read data is valid here: clock ran during reset
                WAKE_MODE   <= nv_rdata[POS_W];
                saved_pos_q <= nv_rdata[POS_W-1:0];
            end else if (state_q == mtwd_pkg::S_IDLE && take && is_ours && is_wake
                    && !reject) begin
                unique case (func)
                    mtwd_pkg::FN_SLEEP: begin
                        saved_pos_q <= CUR_POS;
                        nv_we_q     <= 1'b1;
                        nv_wdata_q  <= {WAKE_MODE, CUR_POS};
                    end
                    mtwd_pkg::FN_SETUP: begin
                        WAKE_MODE   <= 1'b1;
                        saved_pos_q <= CUR_POS;
                        nv_we_q     <= 1'b1;
                        nv_wdata_q  <= {1'b1, CUR_POS};
                    end
                    mtwd_pkg::FN_FINISH: begin
                        WAKE_MODE  <= 1'b0;
                        nv_we_q    <= 1'b1;
                        nv_wdata_q <= {1'b0, saved_pos_q};
                    end
                    default: begin
                        nv_we_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // register port: control write, read data one cycle later
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            en_q <= mtwd_pkg::CTRL_EN_RST;
        end else if (REG_WR && REG_ADDR == mtwd_pkg::REG_CTRL) begin
            en_q <= REG_WDATA[mtwd_pkg::CTRL_EN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= '0;
        end else begin
            REG_RDATA <= '0;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    mtwd_pkg::REG_CTRL:      REG_RDATA <= {31'h0, en_q};
                    mtwd_pkg::REG_STATUS:    REG_RDATA <= {22'h0, STAT.status, !CMD_READY,
                                                           WAKE_MODE};
                    mtwd_pkg::REG_SAVED_POS: REG_RDATA <= 32'(saved_pos_q);
                    mtwd_pkg::REG_SENSE:     REG_RDATA <= {4'h0, STAT.sense_key, STAT.asc,
                                                           8'h0, STAT.fsc};
                    default:                 REG_RDATA <= '0;
                endcase
            end
        end
    end

    // checks
    property p_opcode_gate;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && !is_ours |-> ##1 !STAT_VALID && !LU_FWD_VALID && !MECH_REQ;
    endproperty
    a_opcode_gate: assert property (p_opcode_gate)
        else $error("foreign opcode produced activity");

    property p_forward;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && !CMD_CDB.byte5[mtwd_pkg::SELECT_BIT]
            |-> ##1 LU_FWD_VALID && !STAT_VALID && !MECH_REQ;
    endproperty
    a_forward: assert property (p_forward)
        else $error("ordinary block not handed on");

    property p_reserved;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && is_wake && rsv_func |-> ##1 STAT_VALID
            && STAT.status == mtwd_pkg::ST_CHECK && STAT.asc == mtwd_pkg::ASC_BADFIELD
            && STAT.fsc == mtwd_pkg::FSC_RESERVED && !MECH_REQ;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code not rejected");

    property p_not_mode;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && is_wake && !rsv_func && !WAKE_MODE
            && func != mtwd_pkg::FN_SETUP |-> ##1 STAT_VALID
            && STAT.sense_key == mtwd_pkg::SK_ILLEGAL && STAT.asc == mtwd_pkg::ASC_SEQ
            && STAT.fsc == mtwd_pkg::FSC_NOTMODE && !MECH_REQ;
    endproperty
    a_not_mode: assert property (p_not_mode)
        else $error("function outside wake mode accepted");

    property p_setup_twice;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && is_wake && WAKE_MODE && func == mtwd_pkg::FN_SETUP
            |-> ##1 STAT_VALID && STAT.fsc == mtwd_pkg::FSC_INMODE && !nv_we_q;
    endproperty
    a_setup_twice: assert property (p_setup_twice)
        else $error("repeated setup accepted");

    property p_immed;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && is_wake && !reject && mech_fn && immed
            |-> ##1 STAT_VALID && MECH_REQ && STAT.status == mtwd_pkg::ST_GOOD;
    endproperty
    a_immed: assert property (p_immed)
        else $error("early status not returned at start");

    property p_deferred;
        @(posedge SYS_CLK) disable iff (!RST_N)
        state_q == mtwd_pkg::S_EXEC && !immed_q |->
            (STAT_VALID == $past(MECH_DONE && state_q == mtwd_pkg::S_EXEC) || $past(take));
    endproperty
    a_deferred: assert property (p_deferred)
        else $error("status not tied to completion");

    property p_unload;
        @(posedge SYS_CLK) disable iff (!RST_N)
        MECH_REQ && MECH_OP == mtwd_pkg::FN_UNLOAD |-> !MECH_DRAIN_BUF && !MECH_WRITE_EOD;
    endproperty
    a_unload: assert property (p_unload)
        else $error("unload now drains or marks end");

    property p_setup_mode;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && is_wake && !WAKE_MODE && func == mtwd_pkg::FN_SETUP
            |-> ##1 WAKE_MODE && nv_we_q && nv_wdata_q == {1'b1, $past(CUR_POS)};
    endproperty
    a_setup_mode: assert property (p_setup_mode)
        else $error("setup did not enter and save mode");

    property p_finish;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && is_wake && WAKE_MODE && func == mtwd_pkg::FN_FINISH
            |-> ##1 !WAKE_MODE && nv_we_q && !nv_wdata_q[POS_W];
    endproperty
    a_finish: assert property (p_finish)
        else $error("finish did not leave mode");

    property p_wake_target;
        @(posedge SYS_CLK) disable iff (!RST_N)
        MECH_REQ && MECH_OP == mtwd_pkg::FN_WAKE |-> MECH_POS == saved_pos_q;
    endproperty
    a_wake_target: assert property (p_wake_target)
        else $error("wake target not the saved position");

    property p_sleep_save;
        @(posedge SYS_CLK) disable iff (!RST_N)
        take && is_ours && is_wake && WAKE_MODE && func == mtwd_pkg::FN_SLEEP
            |-> ##1 MECH_REQ && nv_we_q && saved_pos_q == $past(CUR_POS);
    endproperty
    a_sleep_save: assert property (p_sleep_save)
        else $error("sleep did not save position");
endmodule : mtwd_decoder

`default_nettype wire

// *** src/mtwd_nvstore.sv ***
// package of shared constants and types, plus the nonvolatile word store
`default_nettype none

package mtwd_pkg;
    // command block decode
    localparam logic [7:0] OPC_LOAD_UNLOAD = 8'h1b;
    localparam int         IMMED_BIT       = 0;
    localparam int         FUNC_LSB        = 0;
    localparam int         FUNC_W          = 3;
    localparam int         SELECT_BIT      = 7;
    localparam int         SPARE_BIT       = 6;
    // wake function codes
    localparam logic [2:0] FN_SLEEP  = 3'h0;
    localparam logic [2:0] FN_WAKE   = 3'h1;
    localparam logic [2:0] FN_SETUP  = 3'h2;
    localparam logic [2:0] FN_UNLOAD = 3'h3;
    localparam logic [2:0] FN_RSV4   = 3'h4;
    localparam logic [2:0] FN_FINISH = 3'h5;
    localparam logic [2:0] FN_RSV6   = 3'h6;
    localparam logic [2:0] FN_RSV7   = 3'h7;
    // status and sense values
    localparam logic [7:0] ST_GOOD      = 8'h00;
    localparam logic [7:0] ST_CHECK     = 8'h02;
    localparam logic [3:0] SK_NONE      = 4'h0;
    localparam logic [3:0] SK_ILLEGAL   = 4'h5;
    localparam logic [7:0] ASC_NONE     = 8'h00;
    localparam logic [7:0] ASC_BADFIELD = 8'h24;
    localparam logic [7:0] ASC_SEQ      = 8'h2c;
    localparam logic [7:0] ASCQ_ZERO    = 8'h00;
    localparam logic [7:0] FSC_NONE     = 8'h00;
    localparam logic [7:0] FSC_RESERVED = 8'h5b;
    localparam logic [7:0] FSC_NOTMODE  = 8'h50;
    localparam logic [7:0] FSC_INMODE   = 8'h53;
    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_SAVED_POS = 8'h08;
    localparam logic [7:0] REG_SENSE     = 8'h0c;
    localparam int         CTRL_EN_BIT   = 0;
    localparam logic       CTRL_EN_RST   = 1'b1;
    localparam logic [0:0] NV_ADDR_STATE = 1'h0;

    typedef enum logic [2:0] {
        S_BOOT = 3'b000,
        S_IDLE = 3'b001,
        S_EXEC = 3'b010
    } mtwd_state_t;

    typedef struct packed {
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [7:0] byte4;
        logic [7:0] byte5;
    } mtwd_cdb_t;

    typedef struct packed {
        logic [7:0] status;
        logic [3:0] sense_key;
        logic [7:0] asc;
        logic [7:0] ascq;
        logic [7:0] fsc;
    } mtwd_stat_t;
endpackage : mtwd_pkg

// word store standing in for the nonvolatile memory; contents ignore reset
module mtwd_nvstore #(
    parameter int DW    = 33,
    parameter int DEPTH = 2,
    parameter int AW    = 1
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read port, data one cycle after address
    input  wire logic [AW-1:0] raddr,
    output var  logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [DEPTH];

    // blank store on first power-up only; reset must not wipe it
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end
endmodule : mtwd_nvstore

`default_nettype wire

// *** test/mtwd_mech_model.sv ***
// tape mechanics model: finishes each requested operation after a set delay
`default_nettype none

module mtwd_mech_model #(
    parameter int POS_W = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // operation requests
    input  wire logic             req,
    input  wire logic [2:0]       op,
    input  wire logic [POS_W-1:0] tgt,
    output var  logic             done,
    output var  logic [POS_W-1:0] cur_pos,
    // bench controls
    input  wire logic [7:0]       delay,
    input  wire logic             set_en,
    input  wire logic [POS_W-1:0] set_pos
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       busy_q;
    logic [7:0] cnt_q;
    logic [2:0] op_q;

    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (req) begin
            busy_q <= 1'b1;
            cnt_q  <= delay;
            op_q   <= op;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            done   <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // tape position is physical, so it ignores reset
    always_ff @(posedge clk) begin
        if (set_en) cur_pos <= set_pos;
        else if (done && op_q == mtwd_pkg::FN_WAKE) cur_pos <= tgt;
    end
endmodule : mtwd_mech_model

`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the wake-up command decoder
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        mtwd_pkg::mtwd_stat_t st;
        logic [1:0]           kind;
    } mtwd_exp_t;

    logic                 SYS_CLK, RST_N, CMD_VALID, CMD_READY, STAT_VALID, LU_FWD_VALID;
    logic                 MECH_DONE, MECH_REQ, MECH_DRAIN_BUF, MECH_WRITE_EOD, WAKE_MODE;
    logic                 REG_WR, REG_RD, set_en, mode_m, en_m, done_seen, rd_seen;
    mtwd_pkg::mtwd_cdb_t  CMD_CDB, LU_FWD_CDB;
    mtwd_pkg::mtwd_stat_t STAT;
    logic [2:0]           MECH_OP;
    logic [31:0]          CUR_POS, MECH_POS, REG_WDATA, REG_RDATA, set_pos, saved_m, cur_m;
    logic [7:0]           REG_ADDR, delay;
    int                   n_errors, cmp_count, cycles;
    mtwd_exp_t            sq[$];
    mtwd_exp_t            e;
    logic [47:0]          lq[$];
    logic [34:0]          mq[$];
    logic [34:0]          m;
    logic [31:0]          rq[$];

    mtwd_decoder i_dut (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_CDB(CMD_CDB),
        .CMD_READY(CMD_READY), .STAT_VALID(STAT_VALID), .STAT(STAT),
        .LU_FWD_VALID(LU_FWD_VALID), .LU_FWD_CDB(LU_FWD_CDB), .CUR_POS(CUR_POS),
        .MECH_DONE(MECH_DONE), .MECH_REQ(MECH_REQ), .MECH_OP(MECH_OP), .MECH_POS(MECH_POS),
        .MECH_DRAIN_BUF(MECH_DRAIN_BUF), .MECH_WRITE_EOD(MECH_WRITE_EOD),
        .WAKE_MODE(WAKE_MODE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA)
    );

    mtwd_mech_model i_mech (
        .clk(SYS_CLK), .rst_n(RST_N), .req(MECH_REQ), .op(MECH_OP), .tgt(MECH_POS),
        .done(MECH_DONE), .cur_pos(CUR_POS), .delay(delay), .set_en(set_en),
        .set_pos(set_pos)
    );

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    function automatic mtwd_pkg::mtwd_stat_t bad(input logic [7:0] asc, input logic [7:0] fsc);
        return {mtwd_pkg::ST_CHECK, mtwd_pkg::SK_ILLEGAL, asc, 8'h00, fsc};
    endfunction : bad

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        rq.push_back(exp);
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
    endtask : reg_rd

    task automatic rdy();
        for (int i = 0; i < 300 && CMD_READY !== 1'b1; i++) @(posedge SYS_CLK);
    endtask : rdy

    task automatic idle(input string name);
        wait (sq.size() == 0 && mq.size() == 0 && lq.size() == 0);
        @(posedge SYS_CLK);
        rdy();
        $display("test %s done", name);
    endtask : idle

    task automatic newpos();
        logic [31:0] p;
        p = $urandom();
        @(posedge SYS_CLK);
        set_en  <= 1'b1;
        set_pos <= p;
        cur_m = p;
        @(posedge SYS_CLK);
        set_en <= 1'b0;
    endtask : newpos

    // works out the answer first, then offers the block until it is taken
    task automatic cmd(input logic [2:0] fn, input logic imm, input logic sel, input logic [7:0] b0);
        mtwd_pkg::mtwd_cdb_t c;
        mtwd_exp_t           x;
        c = {b0, 7'($urandom()), imm, 16'($urandom()), 5'h00, fn, sel, 1'($urandom()), 6'h00};
        x = '0;
        if (b0 != mtwd_pkg::OPC_LOAD_UNLOAD) begin
        end else if (!sel || !en_m) begin
            lq.push_back(c);
        end else begin
            if (fn[2] && fn != mtwd_pkg::FN_FINISH) begin
                x.st = bad(mtwd_pkg::ASC_BADFIELD, mtwd_pkg::FSC_RESERVED);
            end else if (fn == mtwd_pkg::FN_SETUP) begin
                if (mode_m) x.st = bad(mtwd_pkg::ASC_SEQ, mtwd_pkg::FSC_INMODE);
                else saved_m = cur_m;
                mode_m = 1'b1;
            end else if (!mode_m) begin
                x.st = bad(mtwd_pkg::ASC_SEQ, mtwd_pkg::FSC_NOTMODE);
            end else if (fn == mtwd_pkg::FN_FINISH) begin
                mode_m = 1'b0;
            end else begin
                x.kind = imm ? 2'd1 : 2'd2;
                if (fn == mtwd_pkg::FN_SLEEP) saved_m = cur_m;
                if (fn == mtwd_pkg::FN_WAKE) cur_m = saved_m;
                mq.push_back({fn, saved_m});
            end
            sq.push_back(x);
        end
        @(posedge SYS_CLK);
        CMD_VALID <= 1'b1;
        CMD_CDB   <= c;
        do @(posedge SYS_CLK); while (CMD_READY !== 1'b1);
        CMD_VALID <= 1'b0;
    endtask : cmd

    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end

    // result watcher: each output event takes the oldest expectation
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles > 20000) begin
            n_errors++;
            results();
        end
        if (MECH_DONE === 1'b1) done_seen = 1'b1;
        if (STAT_VALID === 1'b1) begin
            e = (sq.size() == 0) ? '1 : sq.pop_front();
            chk(STAT, e.st);
            if (e.kind == 2'd1) chk(MECH_REQ, 1'b1);
            if (e.kind == 2'd2) chk(done_seen, 1'b1);
            done_seen = 1'b0;
        end
        if (MECH_REQ === 1'b1) begin
            m = (mq.size() == 0) ? '1 : mq.pop_front();
            chk({MECH_OP, MECH_DRAIN_BUF, MECH_WRITE_EOD}, {m[34:32], 2'b00});
            if (m[34:32] == mtwd_pkg::FN_WAKE) chk(MECH_POS, m[31:0]);
            done_seen = 1'b0;
        end
        if (LU_FWD_VALID === 1'b1) chk(LU_FWD_CDB, (lq.size() == 0) ? '1 : lq.pop_front());
        if (rd_seen) chk(REG_RDATA, (rq.size() == 0) ? '1 : rq.pop_front());
        rd_seen = REG_RD;
    end

    initial begin
        RST_N = 1'b0;
        CMD_VALID = 1'b0;
        CMD_CDB = '0;
        REG_ADDR = 8'h00;
        REG_WDATA = 32'h0;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        delay = 8'h03;
        set_en = 1'b0;
        set_pos = 32'h0;
        {mode_m, done_seen, rd_seen, saved_m, cur_m} = '0;
        en_m = 1'b1;
        n_errors = 0;
        cmp_count = 0;
        cycles = 0;
        void'($urandom(32'hb64b));
        repeat (12) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        newpos();
        rdy();
        reg_rd(mtwd_pkg::REG_CTRL, 32'h1);
        reg_wr(8'h10, 32'hffff_ffff);
        reg_rd(8'h10, 32'h0);
        idle("registers");
        for (int f = 0; f < 8; f++) if (f != 2) cmd(3'(f), 1'b0, 1'b1, 8'h1b);
        reg_rd(mtwd_pkg::REG_SENSE, 32'h0524_005b);
        cmd(mtwd_pkg::FN_WAKE, 1'b0, 1'b0, 8'h1b);
        cmd(mtwd_pkg::FN_SETUP, 1'b0, 1'b1, 8'h00);
        idle("outside mode");
        newpos();
        cmd(mtwd_pkg::FN_SETUP, 1'b0, 1'b1, 8'h1b);
        cmd(mtwd_pkg::FN_SETUP, 1'b0, 1'b1, 8'h1b);
        idle("setup");
        reg_rd(mtwd_pkg::REG_SAVED_POS, saved_m);
        reg_rd(mtwd_pkg::REG_STATUS, {22'h0, mtwd_pkg::ST_CHECK, 2'b01});
        delay = 8'd20;
        newpos();
        cmd(mtwd_pkg::FN_SLEEP, 1'b0, 1'b1, 8'h1b);
        newpos();
        cmd(mtwd_pkg::FN_WAKE, 1'b0, 1'b1, 8'h1b);
        delay = 8'd0;
        cmd(mtwd_pkg::FN_UNLOAD, 1'b1, 1'b1, 8'h1b);
        idle("mechanics");
        chk(CUR_POS, cur_m);
        RST_N <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(posedge SYS_CLK);
        rdy();
        chk(WAKE_MODE, 1'b1);
        reg_rd(mtwd_pkg::REG_SAVED_POS, saved_m);
        cmd(mtwd_pkg::FN_WAKE, 1'b0, 1'b1, 8'h1b);
        idle("power cycle");
        cmd(mtwd_pkg::FN_FINISH, 1'b0, 1'b1, 8'h1b);
        idle("finish");
        chk(WAKE_MODE, 1'b0);
        cmd(mtwd_pkg::FN_SLEEP, 1'b0, 1'b1, 8'h1b);
        reg_wr(mtwd_pkg::REG_CTRL, 32'h0);
        en_m = 1'b0;
        cmd(mtwd_pkg::FN_SETUP, 1'b0, 1'b1, 8'h1b);
        reg_wr(mtwd_pkg::REG_CTRL, 32'h1);
        en_m = 1'b1;
        idle("feature off");
        results();
    end
endmodule : testbench

`default_nettype wire
